// ==== far_side_master.sv ====
// Far-side bus master model driving the port's inputs.
// Assumes one caller; each task call takes one rising edge.
`timescale 1ns/100ps
`default_nettype none
module far_side_master (
   input  wire logic        mclk_i,
   output var  logic [18:0] addr_i,
   output var  logic [35:0] data_i,
   output var  logic        processor_addr_strobe_n_i,
   output var  logic        controller_addr_strobe_n_i,
   output var  logic        burst_advance_n_i,
   output var  logic        all_bytes_write_n_i,
   output var  logic [3:0]  byte_lane_write_n_i,
   output var  logic        byte_write_qualifier_n_i,
   output var  logic        pipelined_chip_sel_n_i,
   output var  logic        burst_mode_i,
   output var  logic        output_en_n_i,
   output var  logic        sleep_request_i
);
   initial begin
      {processor_addr_strobe_n_i, controller_addr_strobe_n_i, burst_advance_n_i, all_bytes_write_n_i} = 4'hf;
      {pipelined_chip_sel_n_i, burst_mode_i, output_en_n_i, sleep_request_i} = 4'h0;
      addr_i = 19'h0;
      data_i = 36'h0;
      byte_lane_write_n_i = 4'hf;
      byte_write_qualifier_n_i = 1'b1;
   end
   task automatic op(input logic p, input logic c, input logic a, input logic w,
                     input logic [18:0] ad, input logic [35:0] d);
      @(posedge mclk_i);
      processor_addr_strobe_n_i <= !p;
      controller_addr_strobe_n_i <= !c;
      burst_advance_n_i <= !a;
      all_bytes_write_n_i <= !w;
      byte_write_qualifier_n_i <= 1'b1;
      byte_lane_write_n_i <= 4'hf;
      // Without a strobe the address lines carry junk, so a stray reload would show.
      addr_i <= (p || c) ? ad : ~addr_i;
      data_i <= w ? d : ~data_i;
   endtask
   // Controller-strobe start that writes only the lanes chosen through the qualifier.
   task automatic lane_wr(input logic [3:0] lanes, input logic [18:0] ad, input logic [35:0] d);
      @(posedge mclk_i);
      processor_addr_strobe_n_i <= 1'b1;
      controller_addr_strobe_n_i <= 1'b0;
      burst_advance_n_i <= 1'b1;
      all_bytes_write_n_i <= 1'b1;
      byte_write_qualifier_n_i <= 1'b0;
      byte_lane_write_n_i <= ~lanes;
      addr_i <= ad;
      data_i <= d;
   endtask
   task automatic cfg(input logic [3:0] v);
      @(posedge mclk_i);
      {pipelined_chip_sel_n_i, burst_mode_i, output_en_n_i, sleep_request_i} <= v;
   endtask
endmodule // far_side_master
`default_nettype wire

// ==== sram_array.sv ====
// Storage array with per-lane write enables and registered read data.
// Assumes read and write share one address each cycle; a write shows old data.
`timescale 1ns/100ps
`default_nettype none
`include "sync_burst_sram_regs.svh"

module sram_array #(
   parameter int ADDR_W = `SBS_DEF_ADDR_W,
   parameter int DATA_W = `SBS_DEF_DATA_W,
   parameter int LANES  = `SBS_DEF_LANES
) (
   input  wire logic   mclk_i,
   sram_array_if.store port
);
   localparam int LANE_W = DATA_W / LANES;

   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] rdata_nxt;

   always_comb begin
      rdata_nxt = mem[port.addr];
   end

   always_ff @(posedge mclk_i) begin
      rdata_r <= rdata_nxt;
      for (int l = 0; l < LANES; l++) begin
         if (port.lane_we[l]) begin
            mem[port.addr][l*LANE_W +: LANE_W] <= port.wdata[l*LANE_W +: LANE_W];
         end
      end
   end

   assign port.rdata = rdata_r;
endmodule // sram_array

`default_nettype wire

// ==== sram_array_if.sv ====
// Connection between the port logic and its storage array.
// Assumes one clock shared by both ends.
`timescale 1ns/100ps
`default_nettype none
`include "sync_burst_sram_regs.svh"

interface sram_array_if #(
   parameter int ADDR_W = `SBS_DEF_ADDR_W,
   parameter int DATA_W = `SBS_DEF_DATA_W,
   parameter int LANES  = `SBS_DEF_LANES
);
   logic [ADDR_W-1:0] addr;
   logic [LANES-1:0]  lane_we;
   logic [DATA_W-1:0] wdata;
   logic [DATA_W-1:0] rdata;

   modport ctrl (output addr, output lane_we, output wdata, input rdata);
   modport store (input addr, input lane_we, input wdata, output rdata);
endinterface

`default_nettype wire

// ==== sync_burst_sram_pkg.sv ====
// Types used by the burst memory port; its array uses none of them.
// Assumes the constants header is compiled alongside.
`include "sync_burst_sram_regs.svh"

package sync_burst_sram_pkg;

   typedef logic [`SBS_BURST_W-1:0] burst_t;

   // What the cycle after a clock edge does to the array.
   typedef enum logic [1:0] {
      ACC_IDLE,
      ACC_READ,
      ACC_WRITE
   } access_e;

endpackage

// ==== sync_burst_sram_port.sv ====
// Synchronous flow-through memory port with a two-bit burst counter.
// Assumes all inputs are synchronous to mclk_i except the output enable and sleep,
// and that the far side resolves the shared data wires from data_oe_n_o.
`timescale 1ns/100ps
`default_nettype none
`include "sync_burst_sram_regs.svh"

// Behaviour
// - Every synchronous input is captured on the rising clock edge; here burst_mode_i is not registered and steers the burst address at once.
// - A two-bit counter loads the burst start and steps through remaining beats.
// - Mode high gives interleaved order, mode low gives linear order.
// - Either of the two separate address strobes starts a burst, the processor strobe only while the first chip enable is low.
// - Address and chip enables are registered only while a strobe is active.
// - Later burst addresses come from the counter, stepped by the advance input.
// - Output enable and sleep act without the clock.
// - Array is 512K by 36 or 1M by 18 with a common data bus.
// - A four-beat burst runs two cycles first, then one per beat.
// - The single-enable variant has only the first chip enable.
module sync_burst_sram_port #(
   parameter int ADDR_W    = `SBS_DEF_ADDR_W,
   parameter int DATA_W    = `SBS_DEF_DATA_W,
   parameter int LANES     = `SBS_DEF_LANES,
   parameter bit DEPTH_SEL = `SBS_DEF_DEPTH_SEL
) (
   input  wire logic              mclk_i,
   input  wire logic              srst_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] data_i,
   output var  logic [DATA_W-1:0] data_o,
   output logic                   data_oe_n_o,
   input  wire logic              processor_addr_strobe_n_i,
   input  wire logic              controller_addr_strobe_n_i,
   input  wire logic              burst_advance_n_i,
   input  wire logic              pipelined_chip_sel_n_i,
   input  wire logic              depth_sel_high_i,
   input  wire logic              depth_sel_low_n_i,
   input  wire logic [LANES-1:0]  byte_lane_write_n_i,
   input  wire logic              byte_write_qualifier_n_i,
   input  wire logic              all_bytes_write_n_i,
   input  wire logic              burst_mode_i,
   input  wire logic              output_en_n_i,
   input  wire logic              sleep_request_i,
   output logic [ADDR_W-1:0]      burst_addr_o
);
   // The logic needs address bits above the two-bit burst field and whole byte
   // lanes; both intended shapes, 512K x 36 and 1M x 18, qualify. Other shapes
   // elaborate as well, but the far-side model is only built for 512K x 36.
   if (ADDR_W <= `SBS_BURST_W) begin : g_bad_addr_w
      $error("sync_burst_sram_port: address too narrow for the burst counter");
   end
   if (LANES < 1 || (DATA_W % LANES) != 0) begin : g_bad_lanes
      $error("sync_burst_sram_port: data width does not split into whole lanes");
   end

   // Burst offset for a beat: interleaved XOR or linear add with natural wrap.
   function automatic sync_burst_sram_pkg::burst_t burst_offset(
      input sync_burst_sram_pkg::burst_t start,
      input sync_burst_sram_pkg::burst_t beat,
      input logic                        mode);
      if (mode == `SBS_MODE_INTERLEAVED) begin
         burst_offset = start ^ beat;
      end else begin
         burst_offset = sync_burst_sram_pkg::burst_t'(start + beat);
      end
   endfunction

   localparam int HIGH_W = ADDR_W - `SBS_BURST_W;

   // Full word address of a beat: the high part stays put while the low two
   // bits follow the burst order.
   function automatic logic [ADDR_W-1:0] beat_addr(
      input logic [HIGH_W-1:0]           hi,
      input sync_burst_sram_pkg::burst_t start,
      input sync_burst_sram_pkg::burst_t beat,
      input logic                        mode);
      beat_addr = {hi, burst_offset(start, beat, mode)};
   endfunction

   // Burst address state.
   logic [HIGH_W-1:0]                    base_hi_r;
   logic [HIGH_W-1:0]                    base_hi_nxt;
   sync_burst_sram_pkg::burst_t          start_lo_r;
   sync_burst_sram_pkg::burst_t          start_lo_nxt;
   sync_burst_sram_pkg::burst_t          beat_r;
   sync_burst_sram_pkg::burst_t          beat_nxt;
   logic                                 selected_r;
   logic                                 selected_nxt;
   sync_burst_sram_pkg::access_e         access_r;
   sync_burst_sram_pkg::access_e         access_nxt;

   logic                                 chip_enabled;
   logic                                 proc_start;
   logic                                 ctrl_start;
   logic                                 start;
   logic [LANES-1:0]                     lane_write;
   logic                                 any_write;
   logic [ADDR_W-1:0]                    addr_nxt;

   sram_array_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .LANES(LANES)) arr ();

   // Without the depth pins only the first chip enable takes part.
   always_comb begin
      chip_enabled = !pipelined_chip_sel_n_i;
      if (DEPTH_SEL) begin
         chip_enabled = chip_enabled && depth_sel_high_i && !depth_sel_low_n_i;
      end
   end

   // The processor strobe is ignored while the first chip enable is high, so a
   // deselected device cannot be woken by a processor cycle aimed elsewhere.
   always_comb begin
      proc_start = !processor_addr_strobe_n_i && !pipelined_chip_sel_n_i;
      ctrl_start = !controller_addr_strobe_n_i;
      start      = (proc_start || ctrl_start) && !sleep_request_i;
   end

   // A global write hits every lane; otherwise the qualifier gates the lane enables.
   always_comb begin
      if (!all_bytes_write_n_i) begin
         lane_write = '1;
      end else if (!byte_write_qualifier_n_i) begin
         lane_write = ~byte_lane_write_n_i;
      end else begin
         lane_write = '0;
      end
      any_write = |lane_write;
   end

   // Next address state. A processor-strobe start is always a read; its write, if
   // any, follows on a later edge with the advance input held high.
   always_comb begin
      base_hi_nxt  = base_hi_r;
      start_lo_nxt = start_lo_r;
      beat_nxt     = beat_r;
      selected_nxt = selected_r;
      access_nxt   = sync_burst_sram_pkg::ACC_IDLE;
      // Sleep freezes the whole burst state, so a burst resumes where it stopped
      // once sleep drops; no access is made in the meantime.
      if (sleep_request_i) begin
         access_nxt = sync_burst_sram_pkg::ACC_IDLE;
      end else if (start) begin
         // A start with the other enables false still loads the address, but it
         // leaves the device deselected until the next start.
         selected_nxt = chip_enabled;
         base_hi_nxt  = addr_i[ADDR_W-1:`SBS_BURST_W];
         start_lo_nxt = addr_i[`SBS_BURST_W-1:0];
         beat_nxt     = `SBS_BURST_ZERO;
         if (chip_enabled) begin
            if (ctrl_start && !proc_start && any_write) begin
               access_nxt = sync_burst_sram_pkg::ACC_WRITE;
            end else begin
               access_nxt = sync_burst_sram_pkg::ACC_READ;
            end
         end
      end else if (selected_r) begin
         if (!burst_advance_n_i) begin
            beat_nxt = sync_burst_sram_pkg::burst_t'(beat_r + `SBS_BURST_STEP);
         end
         if (any_write) begin
            access_nxt = sync_burst_sram_pkg::ACC_WRITE;
         end else begin
            access_nxt = sync_burst_sram_pkg::ACC_READ;
         end
      end
   end

   // Inputs are taken only at the rising edge.
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         base_hi_r  <= '0;
         start_lo_r <= `SBS_BURST_ZERO;
         beat_r     <= `SBS_BURST_ZERO;
         selected_r <= 1'b0;
         access_r   <= sync_burst_sram_pkg::ACC_IDLE;
      end else begin
         base_hi_r  <= base_hi_nxt;
         start_lo_r <= start_lo_nxt;
         beat_r     <= beat_nxt;
         selected_r <= selected_nxt;
         access_r   <= access_nxt;
      end
   end

   // The array sees the address in force for the coming cycle, so read data sits
   // in its output register one edge after the address: two cycles for the first
   // beat, then one per advanced beat.
   always_comb begin
      addr_nxt  = beat_addr(base_hi_nxt, start_lo_nxt, beat_nxt, burst_mode_i);
      arr.addr  = addr_nxt;
      arr.wdata = data_i;
      // The array keeps no reset of its own, so nothing is written while reset
      // is held, whatever the far side still drives.
      if (access_nxt == sync_burst_sram_pkg::ACC_WRITE && !srst_i) begin
         arr.lane_we = lane_write;
      end else begin
         arr.lane_we = '0;
      end
   end

   sram_array #(
      .ADDR_W (ADDR_W),
      .DATA_W (DATA_W),
      .LANES  (LANES)
   ) u_array (
      .mclk_i (mclk_i),
      .port   (arr.store)
   );

   // Read data comes from a flip-flop; the burst address from flip-flops and burst_mode_i.
   always_comb begin
      data_o       = arr.rdata;
      burst_addr_o = beat_addr(base_hi_r, start_lo_r, beat_r, burst_mode_i);
   end

   // Drive only for a selected read; output enable and sleep switch the drive
   // off at once, independent of the clock.
   always_comb begin
      data_oe_n_o = output_en_n_i || sleep_request_i ||
                    (access_r != sync_burst_sram_pkg::ACC_READ);
   end
endmodule // sync_burst_sram_port

`default_nettype wire

// ==== sync_burst_sram_port_assertions.sv ====
// Concurrent checks on the burst memory port, bound to its top module.
// Assumes the depth-expansion enables are held true and the mode is steady within a burst.
`timescale 1ns/100ps
`default_nettype none
`include "sync_burst_sram_regs.svh"
module sync_burst_sram_port_checker #(
   parameter int AW = `SBS_DEF_ADDR_W,
   parameter int LN = `SBS_DEF_LANES
) (
   input wire logic          mclk_i,
   input wire logic          srst_i,
   input wire logic [AW-1:0] addr_i,
   input wire logic          data_oe_n_o,
   input wire logic          processor_addr_strobe_n_i,
   input wire logic          controller_addr_strobe_n_i,
   input wire logic          burst_advance_n_i,
   input wire logic          pipelined_chip_sel_n_i,
   input wire logic          all_bytes_write_n_i,
   input wire logic [LN-1:0] byte_lane_write_n_i,
   input wire logic          byte_write_qualifier_n_i,
   input wire logic          burst_mode_i,
   input wire logic          output_en_n_i,
   input wire logic          sleep_request_i,
   input wire logic [AW-1:0] burst_addr_o
);
   logic          go, rd, vld_r;
   logic [1:0]    bt_r, lo;
   logic [AW-1:0] st_r;
   assign go = !sleep_request_i && (!controller_addr_strobe_n_i ||
               !(processor_addr_strobe_n_i || pipelined_chip_sel_n_i));
   // A processor-strobe start is always a read; a controller start reads only with no lane enabled.
   assign rd = go && !pipelined_chip_sel_n_i && (!processor_addr_strobe_n_i ||
               (all_bytes_write_n_i && (byte_write_qualifier_n_i || &byte_lane_write_n_i)));
   assign lo = burst_mode_i ? st_r[1:0] ^ bt_r : st_r[1:0] + bt_r;
   // Reference counter; it is only trusted after a selected start.
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         vld_r <= 1'b0;
      end else if (go) begin
         vld_r <= !pipelined_chip_sel_n_i;
         st_r  <= addr_i;
         bt_r  <= 2'h0;
      end else if (!sleep_request_i && !burst_advance_n_i) begin
         bt_r <= bt_r + 2'h1;
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (srst_i);
   sequence s_read_start;
      rd ##1 !(output_en_n_i || sleep_request_i);
   endsequence
   sequence s_write_start;
      go && !pipelined_chip_sel_n_i && !rd;
   endsequence
   a_read_drives: assert property (s_read_start |-> !data_oe_n_o) else $error("read not driven");
   a_write_quiet: assert property (s_write_start |=> data_oe_n_o) else $error("write drove bus");
   a_async_off: assert property (output_en_n_i || sleep_request_i |-> data_oe_n_o) else $error("drive on");
   a_sleep_hold: assert property (sleep_request_i |=> $stable(burst_addr_o)) else $error("moved in sleep");
   a_start_load: assert property (go && !pipelined_chip_sel_n_i |=> burst_addr_o == $past(addr_i))
      else $error("start address not loaded");
   a_burst_order: assert property (vld_r |-> burst_addr_o == {st_r[AW-1:2], lo})
      else $error("burst address wrong");
   a_deselect_quiet: assert property (go && pipelined_chip_sel_n_i |=> data_oe_n_o) else $error("drove");
   a_refused_strobe: assert property (!processor_addr_strobe_n_i && !go && !vld_r |=> data_oe_n_o)
      else $error("refused strobe drove bus");
endmodule // sync_burst_sram_port_checker
bind sync_burst_sram_port sync_burst_sram_port_checker #(.AW(ADDR_W), .LN(LANES)) u_chk (.*);
`default_nettype wire

// ==== sync_burst_sram_regs.svh ====
// Constants for the synchronous burst memory port: widths, defaults and codes.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef SYNC_BURST_SRAM_REGS_SVH
`define SYNC_BURST_SRAM_REGS_SVH

`define SBS_BURST_W      2
`define SBS_BURST_ZERO   2'h0
`define SBS_BURST_STEP   2'h1
`define SBS_DEF_DATA_W   36
`define SBS_DEF_ADDR_W   19
`define SBS_DEF_LANES    4
`define SBS_DEF_DEPTH_SEL 1
`define SBS_MODE_INTERLEAVED 1'b1

`endif

// ==== tb_sync_burst_sram_port.sv ====
// Self-checking bench of the burst memory port against a far-side master model.
// Assumes default widths with both depth-expansion enables held true.
`timescale 1ns/100ps
`default_nettype none
module tb_sync_burst_sram_port;
   localparam logic [18:0] BASE = 19'h2a5c0;
   logic        mclk_i = 1'b0;
   logic        srst_i = 1'b1;
   logic [18:0] addr_i, burst_addr_o;
   logic [35:0] data_i, data_o;
   logic        data_oe_n_o, processor_addr_strobe_n_i, controller_addr_strobe_n_i, burst_advance_n_i;
   logic        pipelined_chip_sel_n_i, all_bytes_write_n_i, burst_mode_i, output_en_n_i, sleep_request_i;
   logic [3:0]  byte_lane_write_n_i;
   logic        byte_write_qualifier_n_i;
   logic        depth_sel_high_i = 1'b1;
   logic        depth_sel_low_n_i = 1'b0;
   int          error_cnt = 0;
   int          n_checks = 0;
   always #5 mclk_i = ~mclk_i;
   sync_burst_sram_port i_dut (.*);
   far_side_master i_host (.*);
   function automatic logic [35:0] pat(input logic [1:0] j);
      return 36'ha5c30f00 ^ {34'h0, j};
   endfunction
   function automatic logic [1:0] ord(input logic [1:0] s, input logic [1:0] b, input logic m);
      return m ? s ^ b : s + b;
   endfunction
   task automatic cmp(input string what, input logic [35:0] exp, input logic [35:0] got);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic close_out();
      if (error_cnt == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Four beats and an idle edge; each edge's result is looked at in the cycle after it.
   task automatic burst(input logic p, input logic c, input logic w, input logic m, input logic [1:0] s);
      logic [1:0] e;
      for (int k = 0; k < 5; k++) begin
         e = ord(s, 2'(k), m);
         i_host.op(p && k == 0, c && k == 0, k > 0 && k < 4, w && k < 4, {BASE[18:2], s}, pat(e));
         if (k > 0) begin
            e = ord(s, 2'(k - 1), m);
            #1;
            cmp("burst address", 36'({BASE[18:2], e}), 36'(burst_addr_o));
            cmp("bus drive", 36'(w), 36'(data_oe_n_o));
            if (!w) cmp("read data", pat(e), data_o);
         end
      end
   endtask
   task automatic quiet(input logic p, input logic c, input logic [18:0] ad, input logic [18:0] ea);
      i_host.cfg(4'hc);
      i_host.op(p, c, 1'b0, 1'b0, ad, 36'h0);
      i_host.op(1'b0, 1'b0, 1'b0, 1'b0, BASE, 36'h0);
      #1;
      cmp("bus drive", 36'h1, 36'(data_oe_n_o));
      cmp("burst address", 36'(ea), 36'(burst_addr_o));
   endtask
   initial begin
      repeat (8) @(posedge mclk_i);
      srst_i <= 1'b0;
      burst(1'b0, 1'b1, 1'b1, 1'b0, 2'h0);
      burst(1'b1, 1'b0, 1'b0, 1'b0, 2'h1);
      i_host.cfg(4'h4);
      // A write asked on a processor-strobe start must leave the word alone.
      i_host.op(1'b1, 1'b0, 1'b0, 1'b1, {BASE[18:2], 2'h2}, 36'h0);
      i_host.cfg(4'h5);
      #1;
      cmp("bus drive", 36'h1, 36'(data_oe_n_o));
      // The second edge starts a read again, so only the output enable holds the bus off.
      i_host.cfg(4'h6);
      i_host.cfg(4'h6);
      #1;
      cmp("bus drive", 36'h1, 36'(data_oe_n_o));
      i_host.cfg(4'h4);
      #1;
      cmp("bus drive", 36'h0, 36'(data_oe_n_o));
      cmp("read data", pat(2'h2), data_o);
      burst(1'b1, 1'b0, 1'b0, 1'b1, 2'h1);
      burst(1'b0, 1'b1, 1'b0, 1'b1, 2'h3);
      // Qualified write of lane 0 alone, then a controller-strobe read of that word.
      i_host.lane_wr(4'h1, {BASE[18:2], 2'h0}, 36'h0);
      i_host.op(1'b0, 1'b1, 1'b0, 1'b0, {BASE[18:2], 2'h0}, 36'h0);
      i_host.op(1'b0, 1'b0, 1'b0, 1'b0, BASE, 36'h0);
      #1;
      cmp("lane write", pat(2'h0) & ~36'h1ff, data_o);
      quiet(1'b0, 1'b1, BASE ^ 19'h00004, BASE ^ 19'h00004);
      quiet(1'b1, 1'b0, ~BASE, BASE ^ 19'h00004);
      close_out();
   end
   initial begin
      repeat (1000) @(posedge mclk_i);
      error_cnt++;
      close_out();
   end
endmodule // tb_sync_burst_sram_port
`default_nettype wire
